/* logic/ampst_regs.svh */
/*
  Register offsets, field positions and reset values of the amplifier status block.
  Assumes inclusion by bare name from design files.
*/
`ifndef AMPST_REGS_SVH
`define AMPST_REGS_SVH
`define AMPST_CTRL_OFF 8'h00
`define AMPST_STAT_OFF 8'h04
`define AMPST_STAT_RST 32'h0000_0000
`define AMPST_CTRL_RST 32'h0000_0000
`define AMPST_AMP0_EN_BIT 0
`define AMPST_AMP1_EN_BIT 1
`define AMPST_TRG0_EN_BIT 4
`define AMPST_TRG1_EN_BIT 5
`define AMPST_IRQ0_EN_BIT 8
`define AMPST_IRQ1_EN_BIT 9
`define AMPST_LVL0_BIT 0
`define AMPST_LVL1_BIT 1
`define AMPST_FLG0_BIT 4
`define AMPST_FLG1_BIT 5
`define AMPST_SYNC_STAGES 2
`endif

/* logic/ampst_pkg.sv */
/*
  Types shared by the amplifier status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package ampst_pkg;
  // Register bus word
  typedef logic [31:0] ampst_word_t;
endpackage : ampst_pkg
`default_nettype wire

/* logic/ampst_sync.sv */
/*
  Two-stage level synchronizer with change detection for one trigger channel.
  Assumes a synchronous active-high reset on the bus clock.
*/
`default_nettype none
module ampst_sync
  import ampst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw level and gating
  input wire logic trig_in,
  input wire logic trig_en,
  // Results
  output logic level,
  output logic change
);
  // All state of the synchronizer
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } ampst_sync_st_t;
  ampst_sync_st_t st_r, st_nxt;

  // Next state: shift chain, remember gated level
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = trig_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = st_r.s2 & trig_en;
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Gated level, forced low when buffer disabled
  assign level = st_r.s2 & trig_en;
  // Change on either edge of gated level
  assign change = level ^ st_r.prev;
endmodule : ampst_sync
`default_nettype wire

/* logic/ampst_top.sv */
/*
  Amplifier trigger output status block: control and status registers, level readback,
  sticky change flags, interrupt request.
  Assumes a simple synchronous register port (select, write strobe, byte address, data)
  and trigger inputs asynchronous to the bus clock, taken in through two-stage synchronizers.
*/
`default_nettype none
`include "ampst_regs.svh"

module ampst_top
  import ampst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Trigger buffer raw outputs
  input wire logic amp0_trig_in,
  input wire logic amp1_trig_in,
  // Analog controls
  output logic amp0_enable,
  output logic amp1_enable,
  output logic amp0_trigger_buffer_enable,
  output logic amp1_trigger_buffer_enable,
  // Comparator interrupt request
  output logic cmp_irq
);
  // All state of the block
  typedef struct packed {
    logic [31:0] ctrl;
    logic flg0;
    logic flg1;
    logic [31:0] rdata;
    logic irq;
  } ampst_st_t;
  ampst_st_t st_r, st_nxt;

  // Synchronizer results
  logic lvl0, lvl1, chg0, chg1;
  // Decoded strobes
  logic wr_ctrl, wr_stat, rd_any;

  // Channel 0 synchronizer
  ampst_sync u_sync0 (
    .clk(clk),
    .rst(rst),
    .trig_in(amp0_trig_in),
    .trig_en(st_r.ctrl[`AMPST_TRG0_EN_BIT]),
    .level(lvl0),
    .change(chg0)
  );
  // Channel 1 synchronizer
  ampst_sync u_sync1 (
    .clk(clk),
    .rst(rst),
    .trig_in(amp1_trig_in),
    .trig_en(st_r.ctrl[`AMPST_TRG1_EN_BIT]),
    .level(lvl1),
    .change(chg1)
  );

  // Address decode
  assign wr_ctrl = reg_sel & reg_wr & (reg_addr == `AMPST_CTRL_OFF);
  assign wr_stat = reg_sel & reg_wr & (reg_addr == `AMPST_STAT_OFF);
  assign rd_any = reg_sel & ~reg_wr;

  // Status word assembly
  function automatic ampst_word_t stat_word(input logic l0, input logic l1,
                                            input logic f0, input logic f1);
    ampst_word_t w;
    w = '0;
    w[`AMPST_LVL0_BIT] = l0;
    w[`AMPST_LVL1_BIT] = l1;
    w[`AMPST_FLG0_BIT] = f0;
    w[`AMPST_FLG1_BIT] = f1;
    return w;
  endfunction : stat_word

  // Next state
  always_comb begin
    st_nxt = st_r;
    // Control write keeps only defined bits
    if (wr_ctrl) begin
      st_nxt.ctrl = '0;
      st_nxt.ctrl[`AMPST_AMP0_EN_BIT] = reg_wdata[`AMPST_AMP0_EN_BIT];
      st_nxt.ctrl[`AMPST_AMP1_EN_BIT] = reg_wdata[`AMPST_AMP1_EN_BIT];
      st_nxt.ctrl[`AMPST_TRG0_EN_BIT] = reg_wdata[`AMPST_TRG0_EN_BIT];
      st_nxt.ctrl[`AMPST_TRG1_EN_BIT] = reg_wdata[`AMPST_TRG1_EN_BIT];
      st_nxt.ctrl[`AMPST_IRQ0_EN_BIT] = reg_wdata[`AMPST_IRQ0_EN_BIT];
      st_nxt.ctrl[`AMPST_IRQ1_EN_BIT] = reg_wdata[`AMPST_IRQ1_EN_BIT];
    end
    // Write one clears a flag
    if (wr_stat && reg_wdata[`AMPST_FLG0_BIT]) begin
      st_nxt.flg0 = 1'b0;
    end
    if (wr_stat && reg_wdata[`AMPST_FLG1_BIT]) begin
      st_nxt.flg1 = 1'b0;
    end
    // Set wins over clear
    if (chg0) begin
      st_nxt.flg0 = 1'b1;
    end
    if (chg1) begin
      st_nxt.flg1 = 1'b1;
    end
    // Registered read data
    if (rd_any) begin
      case (reg_addr)
        `AMPST_CTRL_OFF: st_nxt.rdata = st_r.ctrl;
        `AMPST_STAT_OFF: st_nxt.rdata = stat_word(lvl0, lvl1, st_r.flg0, st_r.flg1);
        default: st_nxt.rdata = '0;
      endcase
    end
    // Interrupt from enabled flags
    st_nxt.irq = (st_nxt.flg0 & st_nxt.ctrl[`AMPST_IRQ0_EN_BIT]) |
                 (st_nxt.flg1 & st_nxt.ctrl[`AMPST_IRQ1_EN_BIT]);
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.ctrl <= `AMPST_CTRL_RST;
      st_r.flg0 <= 1'b0;
      st_r.flg1 <= 1'b0;
      st_r.rdata <= '0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = st_r.rdata;
  assign amp0_enable = st_r.ctrl[`AMPST_AMP0_EN_BIT];
  assign amp1_enable = st_r.ctrl[`AMPST_AMP1_EN_BIT];
  assign amp0_trigger_buffer_enable = st_r.ctrl[`AMPST_TRG0_EN_BIT];
  assign amp1_trigger_buffer_enable = st_r.ctrl[`AMPST_TRG1_EN_BIT];
  assign cmp_irq = st_r.irq;

  // Checks: control register takes written enables
  a_ctrl_amp0: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> amp0_enable == $past(reg_wdata[`AMPST_AMP0_EN_BIT]))
    else $error("amp0 enable not taken");
  a_trg_en: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> amp1_trigger_buffer_enable == $past(reg_wdata[`AMPST_TRG1_EN_BIT]))
    else $error("trigger1 enable not taken");
  a_trg0_en: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> amp0_trigger_buffer_enable == $past(reg_wdata[`AMPST_TRG0_EN_BIT]))
    else $error("trigger0 enable not taken");
  // Checks: sticky change flags
  a_stat_reset: assert property (@(posedge clk)
    rst |=> !st_r.flg0 && !st_r.flg1)
    else $error("flags not reset");
  a_flag1_set: assert property (@(posedge clk) disable iff (rst)
    chg1 |=> st_r.flg1)
    else $error("flag1 missed change");
  a_flag0_set: assert property (@(posedge clk) disable iff (rst)
    chg0 |=> st_r.flg0)
    else $error("flag0 missed change");
  a_flag_hold: assert property (@(posedge clk) disable iff (rst)
    st_r.flg0 && !(wr_stat && reg_wdata[`AMPST_FLG0_BIT]) |=> st_r.flg0)
    else $error("flag0 lost without clear");
  a_flag1_hold: assert property (@(posedge clk) disable iff (rst)
    st_r.flg1 && !(wr_stat && reg_wdata[`AMPST_FLG1_BIT]) |=> st_r.flg1)
    else $error("flag1 lost without clear");
  a_flag_clear: assert property (@(posedge clk) disable iff (rst)
    wr_stat && reg_wdata[`AMPST_FLG1_BIT] && !chg1 |=> !st_r.flg1)
    else $error("flag1 not cleared");
  a_flag0_clear: assert property (@(posedge clk) disable iff (rst)
    wr_stat && reg_wdata[`AMPST_FLG0_BIT] && !chg0 |=> !st_r.flg0)
    else $error("flag0 not cleared");
  // Checks: level sync latency and status word readback
  a_lvl1_gate: assert property (@(posedge clk) disable iff (rst)
    rd_any && (reg_addr == `AMPST_STAT_OFF) && !amp1_trigger_buffer_enable
      |=> !reg_rdata[`AMPST_LVL1_BIT])
    else $error("level1 not gated");
  a_lvl0_gate: assert property (@(posedge clk) disable iff (rst)
    rd_any && (reg_addr == `AMPST_STAT_OFF) && !amp0_trigger_buffer_enable
      |=> !reg_rdata[`AMPST_LVL0_BIT])
    else $error("level0 not gated");
  a_lvl0_sync: assert property (@(posedge clk) disable iff (rst)
    amp0_trigger_buffer_enable [*3] |-> lvl0 == $past(amp0_trig_in, 2))
    else $error("level0 sync latency");
  a_lvl1_sync: assert property (@(posedge clk) disable iff (rst)
    amp1_trigger_buffer_enable [*3] |-> lvl1 == $past(amp1_trig_in, 2))
    else $error("level1 sync latency");
  a_stat_rd_lvl: assert property (@(posedge clk) disable iff (rst)
    rd_any && (reg_addr == `AMPST_STAT_OFF) |=> reg_rdata[1:0] == $past({lvl1, lvl0}))
    else $error("level bits misread");
  a_stat_rd_flg: assert property (@(posedge clk) disable iff (rst)
    rd_any && (reg_addr == `AMPST_STAT_OFF) |=> reg_rdata[5:4] == $past({st_r.flg1, st_r.flg0}))
    else $error("flag bits misread");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
    rd_any && (reg_addr != `AMPST_CTRL_OFF) && (reg_addr != `AMPST_STAT_OFF)
      |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  // Checks: comparator interrupt request
  a_irq_flag: assert property (@(posedge clk) disable iff (rst)
    cmp_irq |-> (st_r.flg0 && st_r.ctrl[8]) || (st_r.flg1 && st_r.ctrl[9]))
    else $error("irq without enabled flag");
  a_irq_set: assert property (@(posedge clk) disable iff (rst)
    (st_r.flg0 && st_r.ctrl[`AMPST_IRQ0_EN_BIT]) ||
      (st_r.flg1 && st_r.ctrl[`AMPST_IRQ1_EN_BIT]) |-> cmp_irq)
    else $error("enabled flag without irq");
  // Main scenarios reached
  c_flag0: cover property (@(posedge clk) disable iff (rst) chg0 ##1 wr_stat);
  c_irq: cover property (@(posedge clk) disable iff (rst) $rose(cmp_irq));
  c_clash: cover property (@(posedge clk) disable iff (rst) chg1 && wr_stat && reg_wdata[5]);
  c_gate: cover property (@(posedge clk) disable iff (rst) !amp1_trigger_buffer_enable && chg1);
  c_clear0: cover property (@(posedge clk) disable iff (rst)
    wr_stat && reg_wdata[`AMPST_FLG0_BIT] && st_r.flg0);
endmodule : ampst_top
`default_nettype wire

/* tb/ampst_trig_model.sv */
/*
  Behavioural trigger buffer output of one amplifier channel.
  Assumes the bus clock; output is meaningless while the buffer is off.
*/
`default_nettype none
module ampst_trig_model (
  // Clock
  input wire logic clk,
  // Buffer enable and wanted level
  input wire logic buf_en,
  input wire logic level_cmd,
  // Raw trigger output
  output logic trig
);
  timeunit 1ns;
  timeprecision 100ps;
  initial trig = 1'b0;
  // Follows the command when on, toggles when off so gating is exercised
  always @(posedge clk) begin
    trig <= buf_en ? level_cmd : ~trig;
  end
endmodule : ampst_trig_model
`default_nettype wire

/* tb/amp_trigger_output_status_tb.sv */
/*
  Self-checking bench of the amplifier status block.
  Assumes ampst_top and ampst_trig_model are compiled before it.
*/
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); failures++; end end
module amp_trigger_output_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, reg_sel, reg_wr, cmp_irq, cmd0, cmd1, t0, t1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic a0, a1, b0, b1;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  ampst_top ampst_top_i (.clk(clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .amp0_trig_in(t0), .amp1_trig_in(t1), .amp0_enable(a0), .amp1_enable(a1),
    .amp0_trigger_buffer_enable(b0), .amp1_trigger_buffer_enable(b1), .cmp_irq(cmp_irq));
  ampst_trig_model trig0_i (.clk(clk), .buf_en(b0), .level_cmd(cmd0), .trig(t0));
  ampst_trig_model trig1_i (.clk(clk), .buf_en(b1), .level_cmd(cmd1), .trig(t1));
  // Clock source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_sel = 1'b1; reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clk);
    reg_sel = 1'b0; reg_wr = 1'b0;
  endtask : wr
  // Read one word and compare it
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(negedge clk);
    reg_sel = 1'b1; reg_wr = 1'b0; reg_addr = a;
    @(negedge clk);
    reg_sel = 1'b0;
    `CHK(nm, ex, reg_rdata)
  endtask : chk_rd
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask : settle
  task automatic t_reset();
    chk_rd(8'h04, 32'h0000_0000, "status reset");
    chk_rd(8'h00, 32'h0000_0000, "ctrl reset");
    chk_rd(8'h08, 32'h0000_0000, "unmapped read");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ctrl();
    wr(8'h00, 32'hFFFF_FFFF);
    `CHK("ctrl outs", 4'hF, {b1, b0, a1, a0})
    chk_rd(8'h00, 32'h0000_0333, "ctrl bits");
    settle();
    wr(8'h04, 32'h0000_0030);
    chk_rd(8'h04, 32'h0000_0000, "flags cleared");
    `CHK("irq idle", 1'b0, cmp_irq)
    $display("t_ctrl done");
  endtask : t_ctrl
  task automatic t_flag();
    cmd0 = 1'b1;
    settle();
    chk_rd(8'h04, 32'h0000_0011, "rise ch0");
    `CHK("irq ch0", 1'b1, cmp_irq)
    wr(8'h04, 32'h0000_0000);
    chk_rd(8'h04, 32'h0000_0011, "write zero");
    wr(8'h04, 32'h0000_0010);
    chk_rd(8'h04, 32'h0000_0001, "level ch0");
    cmd0 = 1'b0;
    cmd1 = 1'b1;
    settle();
    chk_rd(8'h04, 32'h0000_0032, "fall0 rise1");
    wr(8'h04, 32'h0000_0030);
    $display("t_flag done");
  endtask : t_flag
  // Change seen in the same cycle as a write-one clear
  task automatic t_clash();
    cmd0 = 1'b1;
    repeat (2) @(negedge clk);
    wr(8'h04, 32'h0000_0010);
    chk_rd(8'h04, 32'h0000_0013, "set beats clear");
    cmd0 = 1'b0;
    settle();
    wr(8'h04, 32'h0000_0030);
    chk_rd(8'h04, 32'h0000_0002, "clash cleanup");
    $display("t_clash done");
  endtask : t_clash
  task automatic t_gate();
    wr(8'h00, 32'h0000_0313);
    settle();
    chk_rd(8'h04, 32'h0000_0020, "ch1 gated");
    `CHK("irq ch1", 1'b1, cmp_irq)
    cmd0 = 1'b1;
    wr(8'h00, 32'h0000_0103);
    settle();
    wr(8'h04, 32'h0000_0030);
    chk_rd(8'h04, 32'h0000_0000, "ch0 gated");
    wr(8'h00, 32'h0000_0123);
    `CHK("ctrl mix", 4'b1011, {b1, b0, a1, a0})
    settle();
    chk_rd(8'h04, 32'h0000_0022, "ch1 masked");
    `CHK("irq masked", 1'b0, cmp_irq)
    $display("t_gate done");
  endtask : t_gate
  // Main sequence
  initial begin
    rst = 1'b1; reg_sel = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000; cmd0 = 1'b0; cmd1 = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_ctrl();
    t_flag();
    t_clash();
    t_gate();
    give_verdict();
  end
endmodule : amp_trigger_output_status_tb
`default_nettype wire
